// ===== include/gsc_pkg.sv
package gsc_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int unsigned NGRP = 4;
    localparam int unsigned NIRQ = 4;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_NS      = 5;
    localparam int unsigned TICK_NS     = 1000;
    localparam int unsigned TICK_CYC    = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned INHIBIT_US  = 10;
    localparam int unsigned SHUTDOWN_US = 1000;
    localparam int unsigned CROWBAR_US  = 1000;
    localparam int unsigned PROG_US     = 100;
    localparam int unsigned MS_US       = 1000;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_IRQ_CFG  = 8'h04;
    localparam logic [7:0] REG_AUTO_ON  = 8'h08;
    localparam logic [7:0] REG_STATUS   = 8'h0c;
    localparam logic [7:0] REG_CFG_STAT = 8'h10;
    localparam logic [7:0] REG_CMD      = 8'h14;
    localparam logic [7:0] REG_RT_SAVED = 8'h18;
    localparam logic [7:0] REG_RT_LIVE  = 8'h1c;

    // ************************************************************
    // fields
    // ************************************************************
    localparam int unsigned CTRL_FE_BIT     = 0;
    localparam int unsigned CTRL_CB_EN_BIT  = 1;
    localparam int unsigned CTRL_PROP_BIT   = 2;
    localparam int unsigned CTRL_FLT_FE_BIT = 3;
    localparam int unsigned IRQ_MODE_LSB    = 0;
    localparam int unsigned IRQ_MASK_LSB    = 4;
    localparam int unsigned CMD_ON_LSB      = 0;
    localparam int unsigned CMD_OFF_LSB     = 4;
    localparam int unsigned CMD_PROG_LSB    = 8;
    localparam int unsigned CMD_CB_BIT      = 12;
    localparam int unsigned CMD_CAUSE_BIT   = 13;
    localparam int unsigned CMD_FAULT_BIT   = 14;
    localparam int unsigned ST_OK_LSB       = 0;
    localparam int unsigned ST_ON_LSB       = 4;
    localparam int unsigned ST_FAULT_LSB    = 8;
    localparam int unsigned ST_AC_BIT       = 12;
    localparam int unsigned ST_SOFT_BIT     = 13;
    localparam int unsigned ST_SD_BIT       = 14;
    localparam int unsigned ST_CB_BIT       = 15;
    localparam int unsigned ST_FE_BIT       = 16;
    localparam int unsigned ST_BUSY_BIT     = 17;
    localparam int unsigned ST_INH_LSB      = 20;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [3:0]  CTRL_RST    = 4'h1;
    localparam logic [19:0] IRQ_CFG_RST = 20'h00000;
    localparam logic [3:0]  AUTO_ON_RST = 4'hf;
    localparam logic [10:0] SYNC_RST    = 11'h7ff;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } gsc_wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } gsc_wb_rsp_s;

    typedef enum logic [2:0] {
        ENG_IDLE   = 3'b001,
        ENG_PROG   = 3'b010,
        ENG_FINISH = 3'b100
    } gsc_eng_e;

endpackage

// ===== verilog/gsc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module gsc_sync (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [10:0] async_i,
    output logic      [10:0] level_o
);
    import gsc_pkg::*;

    typedef struct packed {
        logic [10:0] s1;
        logic [10:0] s2;
        logic [10:0] s3;
        logic [10:0] lvl;
    } gsc_sync_s;

    gsc_sync_s   s_q;
    gsc_sync_s   s_d;
    logic [10:0] lvl_nx;

    // ************************************************************
    // three stages, level changes once stages two and three agree
    // ************************************************************
    always_comb begin
        s_d     = s_q;
        s_d.s1  = async_i;
        s_d.s2  = s_q.s1;
        s_d.s3  = s_q.s2;
        s_d.lvl = lvl_nx;
    end

    genvar b;
    generate
        for (b = 0; b < 11; b++) begin : g_bit
            assign lvl_nx[b] = (s_q.s2[b] == s_q.s3[b]) ? s_q.s3[b] : s_q.lvl[b];
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= {4{SYNC_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.lvl;

endmodule
`default_nettype wire

// ===== verilog/gsc_top.sv
// How it works
// - four interrupt inputs, each either a group inhibit or a reprogram trigger
// - inhibit input low drives the OK lines of all its assigned groups low
// - inhibit high again releases those OK lines so converters restart
// - inhibit reaches the OK lines about ten microseconds after the fall
// - converter programming keeps running while an inhibit is held low
// - reprogram trigger input n acts on group n, except that its rise clears config status of all groups
// - trigger falling programs its group, then turns it on if auto-on
// - trigger rising pulls its OK line low at once, clears config status
// - AC-loss or soft shutdown low drives every OK line low
// - that shutdown clears config status and saves the run-time counter
// - status shows whether AC-loss or soft shutdown caused the shutdown
// - after release all groups reprogram, then turn on where auto-on is set
// - AC-loss or soft shutdown reaches the OK lines after about one millisecond
// - front-end enable output high enables, low disables, held in a setting
// - host may switch the front end at any time, last write wins
// - enabled crowbar fires a single one-millisecond high pulse
// - hard reset low clears all state, OK lines low, bus session dropped
// - after hard reset all groups program, then turn on where auto-on is set
// - propagated fault may switch the front end off and fire the crowbar
// - a per-group auto-on setting decides switch-on after programming
`timescale 1ns/1ps
`default_nettype none

module gsc_top #(
    parameter int unsigned SHUTDOWN_TICKS = gsc_pkg::SHUTDOWN_US,
    parameter int unsigned CROWBAR_TICKS  = gsc_pkg::CROWBAR_US,
    parameter int unsigned PROG_TICKS     = gsc_pkg::PROG_US
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire gsc_pkg::gsc_wb_req_s wb_req_i,
    output gsc_pkg::gsc_wb_rsp_s      wb_rsp_o,
    input  wire logic [3:0]           irq_input_n_i,
    input  wire logic                 ac_loss_in_n_i,
    input  wire logic                 soft_shutdown_in_n_i,
    input  wire logic                 hard_reset_in_n_i,
    input  wire logic [3:0]           ok_i,
    output logic      [3:0]           ok_o,
    output logic      [3:0]           ok_oe_o,
    output logic                      front_end_enable_out_o,
    output logic                      crowbar_trigger_out_o,
    output logic                      prog_busy_o,
    output logic      [1:0]           prog_group_o
);
    import gsc_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [3:0]       ctrl;
        logic [19:0]      irq_cfg;
        logic [3:0]       auto_on;
        logic [3:0]       cfg_stat;
        logic [3:0]       on;
        logic [3:0]       pending;
        logic [3:0]       fault;
        logic             ac_cause;
        logic             soft_cause;
        logic             sd_active;
        logic [15:0]      sd_cnt;
        logic [3:0]       irq_prev;
        logic [3:0]       inh_act;
        logic [3:0][3:0]  inh_cnt;
        logic [7:0]       tick_cnt;
        logic             tick;
        logic [9:0]       ms_cnt;
        logic [31:0]      runtime;
        logic [31:0]      rt_saved;
        logic [15:0]      cb_cnt;
        logic             cb_out;
        logic [3:0]       ok_oe;
        logic [3:0]       ok_out;
        logic [3:0][3:0]  oe_hist;
        logic             flt_prev;
        gsc_eng_e         eng;
        logic             busy;
        logic [1:0]       grp;
        logic [15:0]      prog_cnt;
        logic             ack;
        logic [31:0]      rdat;
    } gsc_state_s;

    localparam gsc_state_s S_RST = '{
        ctrl:    CTRL_RST,
        irq_cfg: IRQ_CFG_RST,
        auto_on: AUTO_ON_RST,
        pending: 4'hf,
        irq_prev: 4'hf,
        ok_oe:   4'hf,
        eng:     ENG_IDLE,
        default: '0
    };

    localparam logic [7:0]  TICK_LAST = 8'(TICK_CYC - 1);
    localparam logic [9:0]  MS_LAST   = 10'(MS_US - 1);
    localparam logic [3:0]  INH_LIM   = 4'(INHIBIT_US);
    localparam logic [15:0] SD_LIM    = 16'(SHUTDOWN_TICKS);
    localparam logic [15:0] CB_LIM    = 16'(CROWBAR_TICKS);
    localparam logic [15:0] PROG_LIM  = 16'(PROG_TICKS);

    gsc_state_s  s_q;
    gsc_state_s  n;
    logic [10:0] sy;
    logic [3:0]  sy_irq_n;
    logic        sy_ac_n;
    logic        sy_soft_n;
    logic        sy_hard_n;
    logic [3:0]  sy_ok;
    logic        access;
    logic [31:0] wmask;
    logic [31:0] wdat;
    logic [3:0]  flt_live;
    logic [3:0]  prop_req;
    logic [3:0]  inh_grp;
    logic        any_low;
    logic        cb_fire;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    // sync the interrupt, shutdown, hard-reset and OK input pins
    gsc_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({ok_i, hard_reset_in_n_i, soft_shutdown_in_n_i,
                   ac_loss_in_n_i, irq_input_n_i}),
        .level_o (sy)
    );

    assign sy_irq_n  = sy[3:0];
    assign sy_ac_n   = sy[4];
    assign sy_soft_n = sy[5];
    assign sy_hard_n = sy[6];
    assign sy_ok     = sy[10:7];

    function automatic logic [1:0] lowest(input logic [3:0] v);
        logic [1:0] r;
        r = 2'd0;
        for (int k = 3; k >= 0; k--) begin
            if (v[k]) begin
                r = 2'(k);
            end
        end
        return r;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        n       = s_q;
        n.tick  = 1'b0;
        n.ack   = 1'b0;
        cb_fire = 1'b0;
        access  = wb_req_i.cyc & wb_req_i.stb & ~s_q.ack;
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{wb_req_i.sel[b]}};
        end
        wdat = wb_req_i.dat & wmask;

        // microsecond tick and run-time counter in milliseconds
        if (s_q.tick_cnt == TICK_LAST) begin
            n.tick_cnt = 8'h00;
            n.tick     = 1'b1;
        end else begin
            n.tick_cnt = s_q.tick_cnt + 8'h01;
        end
        if (s_q.tick) begin
            if (s_q.ms_cnt == MS_LAST) begin
                n.ms_cnt  = 10'h000;
                n.runtime = s_q.runtime + 32'h00000001;
            end else begin
                n.ms_cnt = s_q.ms_cnt + 10'h001;
            end
        end

        // bus writes come first so hardware sets below win
        if (access) begin
            n.ack = 1'b1;
            if (wb_req_i.we) begin
                case (wb_req_i.adr)
                    REG_CTRL:    n.ctrl = (s_q.ctrl & ~wmask[3:0]) | wdat[3:0];
                    REG_IRQ_CFG: n.irq_cfg = (s_q.irq_cfg & ~wmask[19:0]) | wdat[19:0];
                    REG_AUTO_ON: n.auto_on = (s_q.auto_on & ~wmask[3:0]) | wdat[3:0];
                    REG_CMD: begin
                        n.on      = (s_q.on | wdat[CMD_ON_LSB +: 4]) & ~wdat[CMD_OFF_LSB +: 4];
                        n.pending = s_q.pending | wdat[CMD_PROG_LSB +: 4];
                        cb_fire   = wdat[CMD_CB_BIT];
                        if (wdat[CMD_CAUSE_BIT]) begin
                            n.ac_cause   = 1'b0;
                            n.soft_cause = 1'b0;
                        end
                        if (wdat[CMD_FAULT_BIT]) begin
                            n.fault = 4'h0;
                        end
                    end
                    default: ;
                endcase
            end else begin
                case (wb_req_i.adr)
                    REG_CTRL:     n.rdat = {28'h0000000, s_q.ctrl};
                    REG_IRQ_CFG:  n.rdat = {12'h000, s_q.irq_cfg};
                    REG_AUTO_ON:  n.rdat = {28'h0000000, s_q.auto_on};
                    REG_STATUS: begin
                        n.rdat = 32'h00000000;
                        n.rdat[ST_OK_LSB +: 4]    = sy_ok;
                        n.rdat[ST_ON_LSB +: 4]    = s_q.on;
                        n.rdat[ST_FAULT_LSB +: 4] = s_q.fault;
                        n.rdat[ST_AC_BIT]         = s_q.ac_cause;
                        n.rdat[ST_SOFT_BIT]       = s_q.soft_cause;
                        n.rdat[ST_SD_BIT]         = s_q.sd_active;
                        n.rdat[ST_CB_BIT]         = s_q.cb_out;
                        n.rdat[ST_FE_BIT]         = s_q.ctrl[CTRL_FE_BIT];
                        n.rdat[ST_BUSY_BIT]       = s_q.busy;
                        n.rdat[ST_INH_LSB +: 4]   = s_q.inh_act;
                    end
                    REG_CFG_STAT: n.rdat = {28'h0000000, s_q.cfg_stat};
                    REG_RT_SAVED: n.rdat = s_q.rt_saved;
                    REG_RT_LIVE:  n.rdat = s_q.runtime;
                    default:      n.rdat = 32'h00000000;
                endcase
            end
        end

        // programming engine
        case (s_q.eng)
            ENG_IDLE: begin
                if (!s_q.sd_active && |s_q.pending) begin
                    n.grp      = lowest(s_q.pending);
                    n.prog_cnt = 16'h0000;
                    n.busy     = 1'b1;
                    n.eng      = ENG_PROG;
                end
            end
            ENG_PROG: begin
                if (s_q.prog_cnt >= PROG_LIM) begin
                    n.eng = ENG_FINISH;
                end else if (s_q.tick) begin
                    n.prog_cnt = s_q.prog_cnt + 16'h0001;
                end
            end
            ENG_FINISH: begin
                n.cfg_stat[s_q.grp] = 1'b1;
                n.pending[s_q.grp]  = 1'b0;
                if (s_q.auto_on[s_q.grp]) begin
                    n.on[s_q.grp] = 1'b1;
                end
                n.busy = 1'b0;
                n.eng  = ENG_IDLE;
            end
            default: begin
                n.busy = 1'b0;
                n.eng  = ENG_IDLE;
            end
        endcase

        // interrupt inputs
        for (int i = 0; i < 4; i++) begin
            n.irq_prev[i] = sy_irq_n[i];
            if (!s_q.irq_cfg[IRQ_MODE_LSB + i]) begin
                if (!sy_irq_n[i]) begin
                    if (s_q.inh_cnt[i] >= INH_LIM) begin
                        n.inh_act[i] = 1'b1;
                    end else if (s_q.tick) begin
                        n.inh_cnt[i] = s_q.inh_cnt[i] + 4'h1;
                    end
                end else begin
                    n.inh_cnt[i] = 4'h0;
                    n.inh_act[i] = 1'b0;
                end
            end else begin
                n.inh_cnt[i] = 4'h0;
                n.inh_act[i] = 1'b0;
                if (s_q.irq_prev[i] && !sy_irq_n[i]) begin
                    n.pending[i] = 1'b1;
                end
                if (!s_q.irq_prev[i] && sy_irq_n[i]) begin
                    n.on[i]      = 1'b0;
                    n.pending[i] = 1'b0;
                    n.cfg_stat   = 4'h0;
                    if (s_q.busy && s_q.grp == 2'(i)) begin
                        n.busy = 1'b0;
                        n.eng  = ENG_IDLE;
                    end
                end
            end
        end

        // AC-loss and soft shutdown
        any_low = ~sy_ac_n | ~sy_soft_n;
        if (any_low) begin
            if (!s_q.sd_active) begin
                if (s_q.sd_cnt >= SD_LIM) begin
                    n.sd_active = 1'b1;
                    n.on        = 4'h0;
                    n.pending   = 4'h0;
                    n.busy      = 1'b0;
                    n.eng       = ENG_IDLE;
                    n.cfg_stat  = 4'h0;
                    n.rt_saved  = s_q.runtime;
                end else if (s_q.tick) begin
                    n.sd_cnt = s_q.sd_cnt + 16'h0001;
                end
            end
            if (s_q.sd_active || s_q.sd_cnt >= SD_LIM) begin
                n.ac_cause   = n.ac_cause | ~sy_ac_n;
                n.soft_cause = n.soft_cause | ~sy_soft_n;
            end
        end else begin
            n.sd_cnt = 16'h0000;
            if (s_q.sd_active) begin
                n.sd_active = 1'b0;
                n.pending   = 4'hf;
            end
        end

        // fault propagation from a converter pulling its own line low
        for (int g = 0; g < 4; g++) begin
            flt_live[g] = s_q.ctrl[CTRL_PROP_BIT] & s_q.on[g] & ~s_q.ok_oe[g]
                          & ~(|s_q.oe_hist[g]) & ~sy_ok[g];
            n.oe_hist[g] = {s_q.oe_hist[g][2:0], s_q.ok_oe[g]};
        end
        n.fault    = n.fault | flt_live;
        n.flt_prev = |flt_live;
        if (|flt_live && !s_q.flt_prev) begin
            if (s_q.ctrl[CTRL_FLT_FE_BIT]) begin
                n.ctrl[CTRL_FE_BIT] = 1'b0;
            end
            cb_fire = 1'b1;
        end

        if (s_q.cb_out) begin
            if (s_q.cb_cnt >= CB_LIM) begin
                n.cb_out = 1'b0;
            end else if (s_q.tick) begin
                n.cb_cnt = s_q.cb_cnt + 16'h0001;
            end
        end else if (cb_fire && s_q.ctrl[CTRL_CB_EN_BIT]) begin
            n.cb_out = 1'b1;
            n.cb_cnt = 16'h0000;
        end

        // OK line drive
        for (int g = 0; g < 4; g++) begin
            inh_grp[g] = 1'b0;
            for (int i = 0; i < 4; i++) begin
                inh_grp[g] = inh_grp[g] | (n.inh_act[i] & s_q.irq_cfg[IRQ_MASK_LSB + 4*i + g]);
            end
            prop_req[g] = |(flt_live & ~(4'h1 << g));
            // any source holds the line low
            n.ok_oe[g] = ~n.on[g] | n.sd_active | inh_grp[g] | prop_req[g];
        end
        n.ok_out = 4'h0;

        if (!sy_hard_n) begin
            // reset state leaves all groups pending
            n = S_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= S_RST;
        end else begin
            s_q <= n;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign wb_rsp_o.ack = s_q.ack;
    assign wb_rsp_o.dat = s_q.rdat;
    assign ok_o         = s_q.ok_out;
    assign ok_oe_o      = s_q.ok_oe;
    assign front_end_enable_out_o = s_q.ctrl[CTRL_FE_BIT];
    assign crowbar_trigger_out_o  = s_q.cb_out;
    assign prog_busy_o            = s_q.busy;
    assign prog_group_o           = s_q.grp;

endmodule
`default_nettype wire

// ===== verification/gsc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module gsc_sva #(
    parameter int unsigned SHUTDOWN_TICKS = 1000,
    parameter int unsigned CROWBAR_TICKS  = 1000,
    parameter int unsigned PROG_TICKS     = 100
) (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire gsc_pkg::gsc_wb_req_s wb_req_i,
    input wire gsc_pkg::gsc_wb_rsp_s wb_rsp_o,
    input wire logic [3:0]           irq_input_n_i,
    input wire logic                 ac_loss_in_n_i,
    input wire logic                 soft_shutdown_in_n_i,
    input wire logic                 hard_reset_in_n_i,
    input wire logic [3:0]           ok_i,
    input wire logic [3:0]           ok_o,
    input wire logic [3:0]           ok_oe_o,
    input wire logic                 front_end_enable_out_o,
    input wire logic                 crowbar_trigger_out_o,
    input wire logic                 prog_busy_o,
    input wire logic [1:0]           prog_group_o
);
    import gsc_pkg::*;
    localparam int SD_LIM = (SHUTDOWN_TICKS + 1) * 200 + 10;
    localparam int CB_MIN = (CROWBAR_TICKS - 1) * 200;
    localparam int CB_MAX = (CROWBAR_TICKS + 1) * 200 + 10;
    int sd_q, cb_q, hr_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****
    // cycle counters
    // ****
    always_ff @(posedge clk_i) sd_q <= (rst_i || (ac_loss_in_n_i && soft_shutdown_in_n_i)) ?
        0 : sd_q + int'(sd_q < SD_LIM);
    always_ff @(posedge clk_i) cb_q <= (rst_i || !crowbar_trigger_out_o) ? 0 : cb_q + 1;
    always_ff @(posedge clk_i) hr_q <= (rst_i || !hard_reset_in_n_i) ? 0 : hr_q + int'(hr_q < 8);
    // ****
    // checks
    // ****
    chk_ack_gap: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held two cycles");
    chk_ack_next: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack && hr_q == 8
        |=> wb_rsp_o.ack) else $error("request not acked");
    chk_rst_vals: assert property ($fell(rst_i) |-> ok_oe_o == 4'hf && front_end_enable_out_o
        && !crowbar_trigger_out_o && !prog_busy_o) else $error("bad reset state");
    chk_hard_rst: assert property (!hard_reset_in_n_i [*8] |-> ok_oe_o == 4'hf
        && !wb_rsp_o.ack && !crowbar_trigger_out_o) else $error("hard reset not applied");
    chk_ok_low: assert property (ok_o == 4'h0) else $error("ok line driven high");
    chk_sd_all: assert property (sd_q == SD_LIM |-> ok_oe_o == 4'hf)
        else $error("shutdown did not pull all lines");
    chk_cb_max: assert property (crowbar_trigger_out_o |-> cb_q < CB_MAX)
        else $error("crowbar pulse too long");
    chk_cb_min: assert property ($fell(crowbar_trigger_out_o) |-> cb_q >= CB_MIN)
        else $error("crowbar pulse too short");
    cover property ($rose(crowbar_trigger_out_o));
    cover property ($rose(prog_busy_o));
    cover property (sd_q == SD_LIM);
endmodule
bind gsc_top gsc_sva #(.SHUTDOWN_TICKS(SHUTDOWN_TICKS), .CROWBAR_TICKS(CROWBAR_TICKS),
    .PROG_TICKS(PROG_TICKS)) u_sva (.*);
`default_nettype wire

// ===== verification/gsc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module gsc_conv_model (
    input  wire logic [3:0] ok_oe_i,
    input  wire logic [3:0] ok_drv_i,
    input  wire logic [3:0] fault_i,
    output logic      [3:0] line_o,
    output logic      [3:0] running_o
);
    // ****
    // shared open-drain lines
    // ****
    // pull-up wins unless pulled
    // a faulty converter pulls its own line low
    assign line_o = (~ok_oe_i & ~fault_i) | ok_drv_i;
    // converters run only on high line
    assign running_o = line_o;
endmodule
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import gsc_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, ac_n = 1'b1, sf_n = 1'b1, hr_n = 1'b1;
    logic [3:0]  irq_n = 4'hf, flt = 4'h0, oe, drv, line;
    logic        fe, cb, busy;
    logic [1:0]  grp;
    logic [31:0] r;
    logic [63:0] nt;
    logic [63:0] q[$];
    gsc_wb_req_s req = '0;
    gsc_wb_rsp_s rsp;
    int          num_errors = 0, total_checks = 0, seed = 15, k, i;
    always #2.5 clk_i = ~clk_i;
    gsc_top #(.SHUTDOWN_TICKS(5), .CROWBAR_TICKS(5), .PROG_TICKS(3)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .irq_input_n_i(irq_n),
        .ac_loss_in_n_i(ac_n), .soft_shutdown_in_n_i(sf_n), .hard_reset_in_n_i(hr_n),
        .ok_i(line), .ok_o(drv), .ok_oe_o(oe), .front_end_enable_out_o(fe),
        .crowbar_trigger_out_o(cb), .prog_busy_o(busy), .prog_group_o(grp));
    gsc_conv_model pm (.ok_oe_i(oe), .ok_drv_i(drv), .fault_i(flt), .line_o(line),
        .running_o());
    // ****
    // helpers
    // ****
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, e, m);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, we, a, 4'hf, d};
        q.push_back({m, e});
        do @(posedge clk_i); while (rsp.ack !== 1'b1);
        req <= '0;
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk_i) if (rsp.ack === 1'b1 && q.size() > 0) begin
        nt = q.pop_front();
        if (nt[63:32] != 0) ck(rsp.dat & nt[63:32], nt[31:0]);
    end
    initial begin
        w(80000);
        num_errors++;
        conclude;
    end
    // ****
    // scenarios
    // ****
    initial begin
        w(4);
        ck(oe, 4'hf);
        rst_i <= 1'b0;
        w(6000);
        wb(0, REG_CFG_STAT, 0, 32'hf, 32'hf);
        ck(oe, 0);
        wb(0, REG_CTRL, 0, 32'(CTRL_RST), 32'hf);
        wb(0, 8'h40, 0, 0, '1);
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            wb(1, REG_CTRL, {30'h0, 1'b1, r[0]}, 0, 0);
            wb(0, REG_CTRL, 0, {30'h0, 1'b1, r[0]}, 32'h3);
            ck(fe, r[0]);
        end
        wb(1, REG_CMD, 32'h1000, 0, 0);
        for (k = 0; k < 50 && cb !== 1'b1; k++) w(1);
        for (k = 0; k < 2000 && cb === 1'b1; k++) w(1);
        ck(k >= 800 && k <= 1220, 1);
        wb(1, REG_IRQ_CFG, 32'h500, 0, 0);
        irq_n[1] <= 1'b0;
        w(1600);
        ck(oe, 0);
        wb(1, REG_CMD, 32'h100, 0, 0);
        for (k = 0; k < 400 && busy !== 1'b1; k++) w(1);
        ck(busy, 1);
        w(1200);
        ck(oe, 4'h5);
        irq_n[1] <= 1'b1;
        w(20);
        ck(oe, 0);
        wb(1, REG_IRQ_CFG, 32'h4, 0, 0);
        wb(1, REG_CMD, 32'h40, 0, 0);
        ck(oe, 4'h4);
        irq_n[2] <= 1'b0;
        for (k = 0; k < 100 && busy !== 1'b1; k++) w(1);
        ck(grp, 2);
        w(1200);
        ck(oe, 0);
        irq_n[2] <= 1'b1;
        w(8);
        ck(oe, 4'h4);
        wb(0, REG_CFG_STAT, 0, 0, 32'hf);
        for (i = 0; i < 2; i++) begin
            wb(1, REG_CMD, 32'h2000, 0, 0);
            {sf_n, ac_n} <= ~(2'b01 << i);
            w(700);
            ck(oe, i ? 0 : 4'h4);
            w(700);
            ck(oe, 4'hf);
            wb(0, REG_STATUS, 0, 32'h1000 << i, 32'h3000);
            wb(0, REG_CFG_STAT, 0, 0, 32'hf);
            {sf_n, ac_n} <= 2'b11;
            w(5000);
            ck(oe, 0);
        end
        wb(1, REG_CTRL, 32'hf, 0, 0);
        flt <= 4'h1;
        w(10);
        ck({oe, fe, cb}, 6'h39);
        flt <= 4'h0;
        w(1300);
        ck({oe, cb}, 0);
        wb(1, REG_CTRL, 0, 0, 0);
        hr_n <= 1'b0;
        w(10);
        ck({oe, fe}, 5'h1f);
        hr_n <= 1'b1;
        w(5000);
        wb(0, REG_CFG_STAT, 0, 32'hf, 32'hf);
        conclude;
    end
endmodule
`default_nettype wire
